// *** logic/sram_host.sv ***
// Host controller that reads and writes an asynchronous 64K x 1 static RAM
`include "sram_host_map.svh"

// What this block does
// - Write starts at the later falling edge of select and strobe.
// - Write ends at the earlier rising edge of select and strobe.
// - Write data held valid before and through the write's end.
// - Address held stable from setup before write until its end.
// - Cycle timing counts from last address valid to next change.
module sram_host (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Request side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [`ADDR_WIDTH-1:0] reqAddr,
  input wire logic reqData,
  output logic rdValid,
  output logic rdData,
  // Memory pins
  output logic [`ADDR_WIDTH-1:0] memAddr,
  output logic memCsN,
  output logic memStrobeN,
  output logic memInBit,
  input wire logic memOutBit
);
  typedef struct packed {
    sram_host_pkg::state_t state;
    logic [`CNT_WIDTH-1:0] count;
    logic write;
    logic [`ADDR_WIDTH-1:0] addr;
    logic data;
    logic csN;
    logic strobeN;
    logic rdValid;
    logic rdData;
  } host_t;

  logic [1:0] rstSync;
  logic rstN;
  logic outLevel;
  host_t h_reg;
  host_t h_next;

  localparam logic [`CNT_WIDTH-1:0] SETUP_CYC = `CNT_WIDTH'(`CYC_ADDR_SETUP);
  localparam logic [`CNT_WIDTH-1:0] PULSE_CYC = `CNT_WIDTH'(`CYC_WRITE_PULSE);
  localparam logic [`CNT_WIDTH-1:0] ACC_CYC = `CNT_WIDTH'(`CYC_ACCESS);
  localparam logic [`CNT_WIDTH-1:0] DESEL_CYC = `CNT_WIDTH'(`CYC_DESELECT);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  sync_in outSync (
    .clock(clock),
    .rstN(rstN),
    .pin(memOutBit),
    .level(outLevel)
  );

  always_comb begin
    h_next = h_reg;
    h_next.rdValid = 1'b0;
    unique case (h_reg.state)
      sram_host_pkg::IDLE: begin
        if (reqValid) begin
          // Address and data latched here stay fixed for the whole cycle
          h_next.addr = reqAddr;
          h_next.data = reqData;
          h_next.write = reqWrite;
          // Strobe stays high until select is settled low
          h_next.csN = 1'b0;
          h_next.strobeN = 1'b1;
          h_next.count = SETUP_CYC;
          h_next.state = sram_host_pkg::SETUP;
        end
      end
      sram_host_pkg::SETUP: begin
        if (h_reg.count > `CNT_WIDTH'(1)) begin
          h_next.count = h_reg.count - `CNT_WIDTH'(1);
        end else if (h_reg.write) begin
          // Strobe falls last, so the write starts on it
          h_next.strobeN = 1'b0;
          h_next.count = PULSE_CYC;
          h_next.state = sram_host_pkg::STROBE;
        end else begin
          // Full access time also covers the old-data hold window
          h_next.count = ACC_CYC;
          h_next.state = sram_host_pkg::READ;
        end
      end
      sram_host_pkg::STROBE: begin
        if (h_reg.count > `CNT_WIDTH'(1)) begin
          h_next.count = h_reg.count - `CNT_WIDTH'(1);
        end else begin
          // Strobe rises first and ends the write; select rises after
          h_next.strobeN = 1'b1;
          h_next.count = DESEL_CYC;
          h_next.state = sram_host_pkg::RECOVER;
        end
      end
      sram_host_pkg::READ: begin
        if (h_reg.count > `CNT_WIDTH'(1)) begin
          h_next.count = h_reg.count - `CNT_WIDTH'(1);
        end else begin
          h_next.rdData = outLevel;
          h_next.rdValid = 1'b1;
          h_next.csN = 1'b1;
          h_next.count = DESEL_CYC;
          h_next.state = sram_host_pkg::RECOVER;
        end
      end
      sram_host_pkg::RECOVER: begin
        // Address and data held for the three cycles past the ending edge
        h_next.csN = 1'b1;
        if (h_reg.count > `CNT_WIDTH'(1)) begin
          h_next.count = h_reg.count - `CNT_WIDTH'(1);
        end else begin
          h_next.state = sram_host_pkg::IDLE;
        end
      end
      default: begin
        h_next.state = sram_host_pkg::IDLE;
        h_next.csN = 1'b1;
        h_next.strobeN = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      h_reg <= '{state: sram_host_pkg::IDLE, count: '0, write: 1'b0,
                 addr: '0, data: 1'b0, csN: 1'b1, strobeN: 1'b1,
                 rdValid: 1'b0, rdData: 1'b0};
    end else begin
      h_reg <= h_next;
    end
  end

  assign reqReady = (h_reg.state == sram_host_pkg::IDLE);
  assign rdValid = h_reg.rdValid;
  assign rdData = h_reg.rdData;
  assign memAddr = h_reg.addr;
  assign memCsN = h_reg.csN;
  assign memStrobeN = h_reg.strobeN;
  assign memInBit = h_reg.data;
endmodule

// *** logic/sram_host_map.svh ***
// Timing constants and sizes for the static RAM host controller
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH

`define CLK_PERIOD_NS 20
`define ADDR_WIDTH 16
`define WORD_COUNT 65536
// Address setup to write start, least time
`define T_ADDR_SETUP_NS 5
// Write pulse width and data setup to end of write, least times
`define T_WRITE_PULSE_NS 55
`define T_DATA_SETUP_NS 30
// Address access time, longest; the host waits at least this long
`define T_ACCESS_NS 70
// Chip-enable high to output high-Z, longest; the host idles this long
`define T_DESELECT_NS 45
`define CYC_ADDR_SETUP \
  ((`T_ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WRITE_PULSE \
  ((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ACCESS ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DESELECT \
  ((`T_DESELECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_WIDTH 3

`endif

// *** logic/sram_host_pkg.sv ***
// Types for the static RAM host controller
package sram_host_pkg;
  typedef enum logic [4:0] {
    IDLE = 5'h01,
    SETUP = 5'h02,
    STROBE = 5'h04,
    READ = 5'h08,
    RECOVER = 5'h10
  } state_t;
endpackage

// *** logic/sync_in.sv ***
// Three-stage synchroniser for the read data pin
module sync_in (
  // Clock and reset
  input wire logic clock,
  input wire logic rstN,
  // Pin and result
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_t;
  sync_t s_reg;
  sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.stage = {s_reg.stage[1:0], pin};
    // A change counts only once the last two stages agree
    if (s_reg.stage[2] == s_reg.stage[1]) begin
      s_next.level = s_reg.stage[2];
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;
endmodule

// *** dv/sram_host_props.sv ***
// Pin timing assertions for the static RAM host controller
module sram_host_props (
  // Clock and reset
  input logic clock,
  input logic nrst,
  // Request side
  input logic reqValid,
  input logic reqReady,
  input logic reqWrite,
  input logic rdValid,
  // Memory pins
  input logic [15:0] memAddr,
  input logic memCsN,
  input logic memStrobeN,
  input logic memInBit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_GATE: assert property (!memStrobeN |-> !memCsN)
    else $error("strobe unselected");
  AST_FALL: assert property ($fell(memStrobeN) |-> !$past(memCsN))
    else $error("strobe fell first");
  AST_RISE: assert property ($rose(memStrobeN) |-> !memCsN)
    else $error("select rose first");
  AST_PULSE: assert property (
    $fell(memStrobeN) |-> !memStrobeN[*3] ##1 memStrobeN)
    else $error("pulse width");
  AST_HOLD: assert property (
    !memCsN && !$past(memCsN) |-> $stable(memAddr) && $stable(memInBit))
    else $error("address moved");
  AST_WRITE: assert property (
    reqValid && reqReady && reqWrite |=> !memCsN ##1 !memStrobeN
    ##3 memStrobeN ##1 memCsN ##2 reqReady) else $error("write walk");
  AST_READ: assert property (
    reqValid && reqReady && !reqWrite |=> !memCsN && memStrobeN
    ##5 rdValid && memCsN ##3 reqReady) else $error("read walk");
  AST_IDLE: assert property ($rose(memCsN) |=> memCsN[*2])
    else $error("deselect short");
endmodule

bind sram_host sram_host_props i_props (.*);

// *** dv/sram_model.sv ***
// Behavioural 64K x 1 static RAM on the far pins
module sram_model (
  // Memory pins
  input logic [15:0] memAddr,
  input logic memCsN,
  input logic memStrobeN,
  input logic memInBit,
  output logic memOutBit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mem [0:65535];
  // Transparent while both low, so the bit at the ending edge sticks
  always @* if (!memCsN && !memStrobeN) mem[memAddr] = memInBit;
  // Off output shows the inverse, so a stray sample is caught
  assign #5 memOutBit = (memCsN || !memStrobeN)
    ? ~mem[memAddr] : mem[memAddr];
endmodule

// *** dv/tb_sram_host.sv ***
// Self-checking bench for the static RAM host controller
module tb_sram_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, reqValid = 0, reqWrite = 0, reqData = 0;
  logic [15:0] reqAddr = 16'h0000;
  logic [15:0] memAddr;
  logic reqReady, rdValid, rdData, memCsN, memStrobeN, memInBit, memOutBit;
  int err_count = 0;
  int samples_checked = 0;
  always #10 clock = ~clock;
  sram_host i_dut (.*);
  sram_model i_mem (.*);
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      err_count++;
    end
  endtask
  // Request held until taken; a read then waits for its pulse
  task automatic access(logic w, logic [15:0] a, logic d, output logic q);
    int n;
    @(negedge clock);
    {reqValid, reqWrite, reqAddr, reqData} = {1'b1, w, a, d};
    for (n = 0; n < 20 && reqReady !== 1'b1; n++) @(negedge clock);
    @(negedge clock);
    reqValid = 0;
    for (; n < 40 && !w && rdValid !== 1'b1; n++) @(negedge clock);
    q = rdData;
    if (n >= 20) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic t_corners();
    logic [15:0] a [4] = '{16'h0000, 16'hffff, 16'h5555, 16'haaaa};
    logic q;
    foreach (a[i]) access(1'b1, a[i], ~i[0], q);
    foreach (a[i]) begin
      access(1'b0, a[i], 1'b0, q);
      check_bit("corner", ~i[0], q);
    end
  endtask
  task automatic t_neighbours();
    logic q;
    access(1'b1, 16'h1235, 1'b0, q);
    access(1'b1, 16'h1234, 1'b1, q);
    access(1'b0, 16'h1235, 1'b0, q);
    check_bit("neighbour", 1'b0, q);
    access(1'b0, 16'h1234, 1'b0, q);
    check_bit("written", 1'b1, q);
    access(1'b1, 16'h1234, 1'b0, q);
    access(1'b0, 16'h1234, 1'b1, q);
    check_bit("rewritten", 1'b0, q);
  endtask
  // Reset lands while the last read is still recovering, before the request is taken and with select high: pins must stay in standby
  task automatic t_reset();
    logic q;
    @(negedge clock);
    {reqValid, reqWrite, reqAddr, reqData} = {1'b1, 1'b1, 16'h0042, 1'b1};
    @(negedge clock);
    reqValid = 0;
    nrst = 0;
    @(negedge clock);
    check_bit("select in reset", 1'b1, memCsN);
    check_bit("strobe in reset", 1'b1, memStrobeN);
    check_bit("ready in reset", 1'b1, reqReady);
    nrst = 1;
    repeat (3) @(negedge clock);
    access(1'b0, 16'h1234, 1'b0, q);
    check_bit("after reset", 1'b0, q);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1;
    repeat (3) @(negedge clock);
    t_corners();
    t_neighbours();
    t_reset();
    stop_test();
  end
endmodule
